// [include/pbc_pkg.sv]
// Shared constants and helpers for both ends of the bus control link.
package pbc_pkg;
  localparam logic [3:0]  CMD_MEM_RD      = 4'h6;
  localparam logic [3:0]  CMD_MEM_WR      = 4'h7;
  localparam logic [3:0]  CMD_CFG_RD      = 4'ha;
  localparam logic [3:0]  CMD_CFG_WR      = 4'hb;
  localparam logic [3:0]  BE_ALL_N        = 4'h0;
  localparam logic [7:0]  CFG_CMD_OFF     = 8'h04;
  localparam logic [7:0]  CFG_BRG_OFF     = 8'h3e;
  localparam logic [7:0]  CFG_MFR_OFF     = 8'h8c;
  localparam logic [15:0] CMD_RST         = 16'h0000;
  localparam logic [15:0] CMD_WMASK       = 16'h0140;
  localparam logic [15:0] BRG_RST         = 16'h0000;
  localparam logic [15:0] BRG_WMASK       = 16'h0002;
  localparam logic [31:0] MFR_RST         = 32'h00000000;
  localparam logic [31:0] MFR_WMASK       = 32'hf7ffffff;
  localparam int          PARITY_ERROR_REPORT_ENABLE_BIT     = 6;
  localparam int          SYSTEM_ERROR_REPORT_ENABLE_BIT     = 8;
  localparam int          CSERR_EN_BIT    = 1;
  localparam int          P7_SEL_LSB      = 28;
  localparam int          P7_IN_BIT       = 27;
  localparam logic [3:0]  P7_SEL_LOCK     = 4'h1;
  localparam int          IDSEL_ALT_BIT   = 23;
  localparam int          WAIT_W          = 8;
  localparam logic [7:0]  DEVSEL_WAIT_CLK = 8'h05;
  localparam int          C_FRAME         = 0;
  localparam int          C_IRDY          = 1;
  localparam int          C_TRDY          = 2;
  localparam int          C_DEVSEL        = 3;
  localparam int          C_STOP          = 4;
  localparam int          C_PERR          = 5;
  localparam logic [5:0]  MSK_INIT        = 6'h03;
  localparam logic [5:0]  MSK_TGT         = 6'h1c;
  localparam logic [7:0]  AV_CTRL         = 8'h00;
  localparam logic [7:0]  AV_ADDR         = 8'h04;
  localparam logic [7:0]  AV_WDATA        = 8'h08;
  localparam logic [7:0]  AV_RDATA        = 8'h0c;
  localparam logic [7:0]  AV_STAT         = 8'h10;
  localparam logic [7:0]  AV_MASK         = 8'h14;
  localparam int          CT_GO           = 0;
  localparam int          CT_WR           = 1;
  localparam int          CT_CFG          = 2;
  localparam int          CT_PARK         = 3;
  localparam int          ST_BUSY         = 4;
  localparam logic [31:0] HOST_BASE_DEF   = 32'h00001000;

  // Even parity: the parity line makes the total count of ones even.
  function automatic logic busParity(input logic [31:0] ad, input logic [3:0] cbe);
    busParity = ^{ad, cbe};
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] beN);
    for (int i = 0; i < 4; i++)
      mergeBytes[8*i +: 8] = beN[i] ? old[8*i +: 8] : wd[8*i +: 8];
  endfunction
endpackage

// [include/pbc_bus_if.sv]
// Shared bus wires between the device end and the host end, resolved from enables.
interface pbc_bus_if;
  logic [31:0] ad;
  logic [3:0]  cbe;
  logic        par;
  logic [5:0]  ctl;
  logic        serrN;
  logic        p7;
  logic [31:0] devAdO, hstAdO;
  logic [3:0]  devCbeO, hstCbeO;
  logic        devAdOe, hstAdOe, devCbeOe, hstCbeOe;
  logic        devParO, hstParO, devParOe, hstParOe;
  logic [5:0]  devCtlO, hstCtlO, devCtlOe, hstCtlOe;
  logic        devReqN, devSerrO, devSerrOe, devP7O, devP7Oe;
  logic        hstGntN, hstIdsel;

  // Undriven lines read as zero for data and as released-high for controls.
  assign ad    = devAdOe ? devAdO : (hstAdOe ? hstAdO : '0);
  assign cbe   = devCbeOe ? devCbeO : (hstCbeOe ? hstCbeO : '0);
  assign par   = devParOe ? devParO : (hstParOe ? hstParO : 1'b0);
  assign ctl   = (devCtlOe & devCtlO) | (hstCtlOe & hstCtlO) | ~(devCtlOe | hstCtlOe);
  assign serrN = devSerrOe ? devSerrO : 1'b1;
  assign p7    = devP7Oe ? devP7O : hstIdsel;

  modport dev (input ad, cbe, par, ctl, serrN, p7, hstGntN,
               output devAdO, devAdOe, devCbeO, devCbeOe, devParO, devParOe, devCtlO, devCtlOe,
               devReqN, devSerrO, devSerrOe, devP7O, devP7Oe);
  modport hst (input ad, cbe, par, ctl, serrN, devReqN,
               output hstAdO, hstAdOe, hstCbeO, hstCbeOe, hstParO, hstParOe, hstCtlO, hstCtlOe,
               hstGntN, hstIdsel);
endinterface

// [hdl/pbc_device_end.sv]
// Device end: config target, single-phase initiator, parity and error signalling.
// Functional notes
// [RULE1] Target claims its own cycles with device select.
// [RULE2] Initiator aborts when no device select arrives.
// [RULE3] Initiator drives frame; transfers run while asserted.
// [RULE4] Frame released marks the last data phase.
// [RULE5] Grant may arrive unrequested; parked grant accepted.
// [RULE6] Request asserted whenever initiator work waits.
// [RULE7] Config cycles answered only with select asserted.
// [RULE8] Strap low: select taken from address 23.
// [RULE9] Data moves only with both readies asserted.
// [RULE10] Otherwise each clock is a wait state.
// [RULE11] Shared pin carries lock only when routed.
// [RULE12] Parity error driven only when reporting enabled.
// [RULE13] System error pulsed when enabled, any cycle.
// [RULE14] Card address parity error pulses system error.
// [RULE15] Target stop ends the transaction at initiator.
// [RULE16] Even parity driven on parity line one clock later.
// [RULE17] Target compares own parity with supplied parity.
// [RULE18] Everything on rising clock; reset returns idle.
module pbc_device_end #(
  parameter logic [pbc_pkg::WAIT_W-1:0] DevselWait = pbc_pkg::DEVSEL_WAIT_CLK
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        strapN,
  input  wire logic        cardAddrParErr,
  input  wire logic        reqValid,
  output      logic        reqReady,
  input  wire logic        reqWrite,
  input  wire logic [31:0] reqAddr,
  input  wire logic [31:0] reqData,
  input  wire logic        reqLock,
  output      logic        rspValid,
  output      logic        rspAbort,
  output      logic [31:0] rspData,
  pbc_bus_if.dev           bus
);
  import pbc_pkg::*;

  typedef enum logic [4:0]
  {
    ST_IDLE  = 5'h01,
    ST_TDATA = 5'h02,
    ST_IADDR = 5'h04,
    ST_IDATA = 5'h08,
    ST_TURN  = 5'h10
  } pbc_dev_state_t;

  pbc_dev_state_t    state_ff, nxt_state;
  logic              strapMeta_ff, strapSync_ff, strapDone_ff, multiPin_ff;
  logic              prevFrameN_ff, tgtWr_ff, turnInit_ff;
  logic [5:0]        tgtIdx_ff;
  logic [15:0]       cmd_ff, brg_ff;
  logic [31:0]       mfr_ff;
  logic              pend_ff, iWr_ff, iLock_ff, devSeen_ff;
  logic [31:0]       iAddr_ff, iData_ff;
  logic [WAIT_W-1:0] waitCnt_ff;
  logic              rspValid_ff, rspAbort_ff;
  logic [31:0]       rspData_ff;
  logic              parCalc_ff, chkAddr_ff, chkData_ff, perr_ff, serr_ff, parO_ff, parOe_ff;
  logic              idleBus, addrPhase, effIdsel, cfgHit, claim, start, dataDone;
  logic              iStop, iAbort, iEnd, parBad, p7Lock;
  logic [31:0]       cfgRdata, cfgWr, adO;
  logic [3:0]        cbeO;
  logic              adOe, cbeOe;
  logic [5:0]        ctlO, ctlOe;

  // The strap is a static pin, still synchronised; its level is caught once after reset release.
  always_ff @(posedge sys_clk)
  begin
    strapMeta_ff <= strapN;
    strapSync_ff <= strapMeta_ff;
  end

  always_ff @(posedge sys_clk)
    if (!rst_n)
    begin
      strapDone_ff <= 1'b0;
      multiPin_ff  <= 1'b0;
    end
    else if (!strapDone_ff)
    begin
      strapDone_ff <= 1'b1;
      multiPin_ff  <= !strapSync_ff;  // [RULE8]
    end

  assign idleBus   = bus.ctl[C_FRAME] && bus.ctl[C_IRDY];
  assign addrPhase = prevFrameN_ff && !bus.ctl[C_FRAME];
  assign effIdsel  = multiPin_ff ? bus.ad[IDSEL_ALT_BIT] : bus.p7;  // [RULE7] [RULE8]
  assign cfgHit    = (bus.cbe == CMD_CFG_RD || bus.cbe == CMD_CFG_WR) && bus.ad[1:0] == 2'b00;
  assign claim     = state_ff == ST_IDLE && addrPhase && effIdsel && cfgHit;  // [RULE1] [RULE7]
  assign start     = state_ff == ST_IDLE && !claim && pend_ff && !bus.hstGntN && idleBus;  // [RULE5]
  assign dataDone  = !bus.ctl[C_IRDY] && !bus.ctl[C_TRDY];  // [RULE9] [RULE10]
  assign iStop     = !bus.ctl[C_STOP] && bus.ctl[C_TRDY];  // [RULE15]
  assign iAbort    = bus.ctl[C_DEVSEL] && !devSeen_ff && waitCnt_ff == DevselWait - 1'b1;  // [RULE2]
  assign iEnd      = state_ff == ST_IDATA && (dataDone || iStop || iAbort);
  assign parBad    = bus.par != parCalc_ff;
  assign p7Lock    = multiPin_ff && mfr_ff[P7_SEL_LSB +: 4] == P7_SEL_LOCK;
  assign reqReady  = state_ff == ST_IDLE && !pend_ff;
  assign rspValid  = rspValid_ff;
  assign rspAbort  = rspAbort_ff;
  assign rspData   = rspData_ff;

  always_comb
  begin
    cfgRdata = '0;
    case (tgtIdx_ff)
      CFG_CMD_OFF[7:2]: cfgRdata = {16'h0000, cmd_ff};
      CFG_BRG_OFF[7:2]: cfgRdata = {brg_ff, 16'h0000};
      CFG_MFR_OFF[7:2]: cfgRdata = {mfr_ff[31:28], bus.p7, mfr_ff[26:0]};
      default:          cfgRdata = '0;
    endcase
    cfgWr = mergeBytes(cfgRdata, bus.ad, bus.cbe);
  end

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
        if (claim)
          nxt_state = ST_TDATA;
        else if (start)
          nxt_state = ST_IADDR;
      ST_TDATA:
        if (dataDone)
          nxt_state = ST_TURN;
      ST_IADDR: nxt_state = ST_IDATA;
      ST_IDATA:
        if (iEnd)
          nxt_state = ST_TURN;
      ST_TURN:  nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
    if (!rst_n)
    begin
      state_ff      <= ST_IDLE;  // [RULE18]
      prevFrameN_ff <= 1'b1;
      turnInit_ff   <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      prevFrameN_ff <= bus.ctl[C_FRAME];
      turnInit_ff   <= state_ff == ST_IDATA;
    end

  always_ff @(posedge sys_clk)
    if (!rst_n)
    begin
      tgtIdx_ff <= '0;
      tgtWr_ff  <= 1'b0;
    end
    else if (claim)
    begin
      tgtIdx_ff <= bus.ad[7:2];
      tgtWr_ff  <= bus.cbe == CMD_CFG_WR;
    end

  // Config writes land at the edge that completes the data phase; byte enables select lanes.
  always_ff @(posedge sys_clk)
    if (!rst_n)
    begin
      cmd_ff <= CMD_RST;
      brg_ff <= BRG_RST;
      mfr_ff <= MFR_RST;
    end
    else if (state_ff == ST_TDATA && dataDone && tgtWr_ff)  // [RULE9]
      case (tgtIdx_ff)
        CFG_CMD_OFF[7:2]: cmd_ff <= cfgWr[15:0] & CMD_WMASK;
        CFG_BRG_OFF[7:2]: brg_ff <= cfgWr[31:16] & BRG_WMASK;
        CFG_MFR_OFF[7:2]: mfr_ff <= cfgWr & MFR_WMASK;
        default:          cmd_ff <= cmd_ff;
      endcase

  always_ff @(posedge sys_clk)
    if (!rst_n)
    begin
      pend_ff  <= 1'b0;
      iWr_ff   <= 1'b0;
      iLock_ff <= 1'b0;
      iAddr_ff <= '0;
      iData_ff <= '0;
    end
    else if (reqValid && reqReady)
    begin
      pend_ff  <= 1'b1;  // [RULE6]
      iWr_ff   <= reqWrite;
      iLock_ff <= reqLock;
      iAddr_ff <= reqAddr;
      iData_ff <= reqData;
    end
    else if (start)
      pend_ff <= 1'b0;

  // A target that answers late keeps the phase waiting; only a missing device select times out.
  always_ff @(posedge sys_clk)
    if (!rst_n)
    begin
      waitCnt_ff <= '0;
      devSeen_ff <= 1'b0;
    end
    else if (state_ff == ST_IADDR)
    begin
      waitCnt_ff <= '0;
      devSeen_ff <= 1'b0;
    end
    else if (state_ff == ST_IDATA)
    begin
      waitCnt_ff <= waitCnt_ff + 1'b1;  // [RULE10]
      devSeen_ff <= devSeen_ff || !bus.ctl[C_DEVSEL];
    end

  always_ff @(posedge sys_clk)
    if (!rst_n)
    begin
      rspValid_ff <= 1'b0;
      rspAbort_ff <= 1'b0;
      rspData_ff  <= '0;
    end
    else
    begin
      rspValid_ff <= iEnd;
      rspAbort_ff <= iEnd && !dataDone;  // [RULE2] [RULE15]
      if (state_ff == ST_IDATA && dataDone && !iWr_ff)
        rspData_ff <= bus.ad;
    end

  always_ff @(posedge sys_clk)
    if (!rst_n)
    begin
      parCalc_ff <= 1'b0;
      chkAddr_ff <= 1'b0;
      chkData_ff <= 1'b0;
      perr_ff    <= 1'b0;
      serr_ff    <= 1'b0;
      parO_ff    <= 1'b0;
      parOe_ff   <= 1'b0;
    end
    else
    begin
      parCalc_ff <= busParity(bus.ad, bus.cbe);  // [RULE17]
      chkAddr_ff <= addrPhase && state_ff == ST_IDLE;
      chkData_ff <= state_ff == ST_TDATA && dataDone && tgtWr_ff;
      perr_ff    <= chkData_ff && parBad && cmd_ff[PARITY_ERROR_REPORT_ENABLE_BIT];  // [RULE12] [RULE17]
      serr_ff    <= (chkAddr_ff && parBad && cmd_ff[SYSTEM_ERROR_REPORT_ENABLE_BIT])
                    || (cardAddrParErr && brg_ff[CSERR_EN_BIT]);  // [RULE13] [RULE14]
      parO_ff    <= busParity(adO, cbeO);  // [RULE16]
      parOe_ff   <= adOe;
    end

  always_comb
  begin
    adO   = '0;
    adOe  = 1'b0;
    cbeO  = BE_ALL_N;
    cbeOe = 1'b0;
    ctlO  = '1;
    ctlOe = '0;
    unique case (state_ff)
      ST_IDLE:  ctlOe = '0;
      ST_TDATA:
      begin
        ctlOe          = MSK_TGT;
        ctlO[C_DEVSEL] = 1'b0;  // [RULE1]
        ctlO[C_TRDY]   = 1'b0;
        ctlO[C_STOP]   = bus.ctl[C_FRAME];  // [RULE15]
        adOe           = !tgtWr_ff;
        adO            = cfgRdata;
      end
      ST_IADDR:
      begin
        ctlOe         = MSK_INIT;
        ctlO[C_FRAME] = 1'b0;  // [RULE3]
        adOe          = 1'b1;
        adO           = iAddr_ff;
        cbeOe         = 1'b1;
        cbeO          = iWr_ff ? CMD_MEM_WR : CMD_MEM_RD;
      end
      ST_IDATA:
      begin
        ctlOe        = MSK_INIT;
        ctlO[C_IRDY] = 1'b0;  // [RULE4]
        adOe         = iWr_ff;
        adO          = iData_ff;
        cbeOe        = 1'b1;
      end
      ST_TURN:  ctlOe = turnInit_ff ? MSK_INIT : MSK_TGT;
    endcase
    ctlOe[C_PERR] = perr_ff;
    ctlO[C_PERR]  = !perr_ff;
  end

  assign bus.devAdO    = adO;
  assign bus.devAdOe   = adOe;
  assign bus.devCbeO   = cbeO;
  assign bus.devCbeOe  = cbeOe;
  assign bus.devCtlO   = ctlO;
  assign bus.devCtlOe  = ctlOe;
  assign bus.devParO   = parO_ff;
  assign bus.devParOe  = parOe_ff;
  assign bus.devReqN   = !pend_ff;  // [RULE6]
  assign bus.devSerrO  = 1'b0;
  assign bus.devSerrOe = serr_ff;
  // Lock is held only across this end's own address and data phases.
  assign bus.devP7Oe   = p7Lock;  // [RULE11]
  assign bus.devP7O    = !(iLock_ff && (state_ff == ST_IADDR || state_ff == ST_IDATA));
endmodule

// [hdl/pbc_host_end.sv]
// Host end: arbiter, config initiator under Avalon control, small memory target.
module pbc_host_end #(
  parameter logic [pbc_pkg::WAIT_W-1:0] DevselWait = pbc_pkg::DEVSEL_WAIT_CLK,
  parameter logic [31:0]                HostBase   = pbc_pkg::HOST_BASE_DEF,
  parameter int                         MemWords   = 4
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  output      logic        irq,
  pbc_bus_if.hst           bus
);
  import pbc_pkg::*;

  localparam int MW = $clog2(MemWords);

  typedef enum logic [4:0]
  {
    H_IDLE  = 5'h01,
    H_ADDR  = 5'h02,
    H_DATA  = 5'h04,
    H_TDATA = 5'h08,
    H_TURN  = 5'h10
  } pbc_host_state_t;

  pbc_host_state_t   state_ff, nxt_state;
  logic              ack_ff, goPend_ff, devGnt_ff, prevFrameN_ff, tgtWr_ff, turnInit_ff, parO_ff, parOe_ff;
  logic [3:0]        ctrl_ff, stat_ff, mask_ff;
  logic [31:0]       addr_ff, wdata_ff, rdata_ff, avRd_ff;
  logic [MW-1:0]     tgtIdx_ff;
  logic [31:0]       mem_ff [MemWords];
  logic [WAIT_W-1:0] waitCnt_ff;
  logic              devSeen_ff, wrEn, idleBus, addrPhase, claim, start, dataDone, hEnd, hAbort;
  logic [3:0]        events;
  logic [31:0]       avRd, adO;
  logic [3:0]        cbeO;
  logic              adOe, cbeOe;
  logic [5:0]        ctlO, ctlOe;

  // One wait state on every access; read data is registered and stands with waitrequest low.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  assign avs_readdata    = avRd_ff;
  assign wrEn            = avs_write && ack_ff;
  assign irq             = |(stat_ff & mask_ff);

  assign idleBus   = bus.ctl[C_FRAME] && bus.ctl[C_IRDY];
  assign addrPhase = prevFrameN_ff && !bus.ctl[C_FRAME];
  assign claim     = state_ff == H_IDLE && addrPhase && (bus.cbe == CMD_MEM_RD || bus.cbe == CMD_MEM_WR)
                     && ((bus.ad ^ HostBase) >> (MW + 2)) == 32'h00000000;
  assign start     = state_ff == H_IDLE && !claim && goPend_ff && !devGnt_ff && idleBus;
  assign dataDone  = !bus.ctl[C_IRDY] && !bus.ctl[C_TRDY];
  assign hAbort    = (!bus.ctl[C_STOP] && bus.ctl[C_TRDY])
                     || (bus.ctl[C_DEVSEL] && !devSeen_ff && waitCnt_ff == DevselWait - 1'b1);
  assign hEnd      = state_ff == H_DATA && (dataDone || hAbort);
  assign events    = {!bus.serrN, !bus.ctl[C_PERR], hEnd && !dataDone, hEnd && dataDone};

  always_comb
  begin
    avRd = '0;
    case (avs_address)
      AV_CTRL:  avRd = {28'h0000000, ctrl_ff};
      AV_ADDR:  avRd = addr_ff;
      AV_WDATA: avRd = wdata_ff;
      AV_RDATA: avRd = rdata_ff;
      AV_STAT:  avRd = {27'h0000000, state_ff != H_IDLE || goPend_ff, stat_ff};
      AV_MASK:  avRd = {28'h0000000, mask_ff};
      default:  avRd = '0;
    endcase
  end

  always_ff @(posedge sys_clk)
    if (!rst_n)
    begin
      ack_ff   <= 1'b0;
      avRd_ff  <= '0;
      ctrl_ff  <= '0;
      addr_ff  <= '0;
      wdata_ff <= '0;
      mask_ff  <= '0;
    end
    else
    begin
      ack_ff  <= (avs_read || avs_write) && !ack_ff;
      avRd_ff <= avRd;
      if (wrEn && avs_address == AV_CTRL)
        ctrl_ff <= avs_writedata[3:0] & 4'he;
      if (wrEn && avs_address == AV_ADDR)
        addr_ff <= avs_writedata;
      if (wrEn && avs_address == AV_WDATA)
        wdata_ff <= avs_writedata;
      if (wrEn && avs_address == AV_MASK)
        mask_ff <= avs_writedata[3:0];
    end

  // A new event outranks a software clear arriving in the same cycle.
  always_ff @(posedge sys_clk)
    if (!rst_n)
      stat_ff <= '0;
    else
      stat_ff <= (stat_ff & ~((wrEn && avs_address == AV_STAT) ? avs_writedata[3:0] : 4'h0)) | events;

  always_ff @(posedge sys_clk)
    if (!rst_n)
    begin
      goPend_ff <= 1'b0;
      devGnt_ff <= 1'b0;
    end
    else
    begin
      if (wrEn && avs_address == AV_CTRL && avs_writedata[CT_GO])
        goPend_ff <= 1'b1;
      else if (start)
        goPend_ff <= 1'b0;
      devGnt_ff <= !goPend_ff && state_ff == H_IDLE && (!bus.devReqN || ctrl_ff[CT_PARK]);
    end

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      H_IDLE:
        if (claim)
          nxt_state = H_TDATA;
        else if (start)
          nxt_state = H_ADDR;
      H_ADDR:  nxt_state = H_DATA;
      H_DATA:
        if (hEnd)
          nxt_state = H_TURN;
      H_TDATA:
        if (dataDone)
          nxt_state = H_TURN;
      H_TURN:  nxt_state = H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
    if (!rst_n)
    begin
      state_ff      <= H_IDLE;
      prevFrameN_ff <= 1'b1;
      turnInit_ff   <= 1'b0;
      waitCnt_ff    <= '0;
      devSeen_ff    <= 1'b0;
      rdata_ff      <= '0;
      tgtIdx_ff     <= '0;
      tgtWr_ff      <= 1'b0;
      parO_ff       <= 1'b0;
      parOe_ff      <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      prevFrameN_ff <= bus.ctl[C_FRAME];
      turnInit_ff   <= state_ff == H_DATA;
      waitCnt_ff    <= state_ff == H_DATA ? waitCnt_ff + 1'b1 : '0;
      devSeen_ff    <= state_ff == H_DATA && (devSeen_ff || !bus.ctl[C_DEVSEL]);
      parO_ff       <= busParity(adO, cbeO);
      parOe_ff      <= adOe;
      if (state_ff == H_DATA && dataDone && !ctrl_ff[CT_WR])
        rdata_ff <= bus.ad;
      if (claim)
      begin
        tgtIdx_ff <= bus.ad[MW+1:2];
        tgtWr_ff  <= bus.cbe == CMD_MEM_WR;
      end
    end

  always_ff @(posedge sys_clk)
    if (!rst_n)
      for (int i = 0; i < MemWords; i++)
        mem_ff[i] <= '0;
    else if (state_ff == H_TDATA && dataDone && tgtWr_ff)
      mem_ff[tgtIdx_ff] <= mergeBytes(mem_ff[tgtIdx_ff], bus.ad, bus.cbe);

  always_comb
  begin
    adO   = '0;
    adOe  = 1'b0;
    cbeO  = BE_ALL_N;
    cbeOe = 1'b0;
    ctlO  = '1;
    ctlOe = '0;
    unique case (state_ff)
      H_IDLE:  ctlOe = '0;
      H_ADDR:
      begin
        ctlOe         = MSK_INIT;
        ctlO[C_FRAME] = 1'b0;
        adOe          = 1'b1;
        adO           = addr_ff;
        cbeOe         = 1'b1;
        cbeO          = ctrl_ff[CT_CFG] ? (ctrl_ff[CT_WR] ? CMD_CFG_WR : CMD_CFG_RD)
                                        : (ctrl_ff[CT_WR] ? CMD_MEM_WR : CMD_MEM_RD);
      end
      H_DATA:
      begin
        ctlOe        = MSK_INIT;
        ctlO[C_IRDY] = 1'b0;
        adOe         = ctrl_ff[CT_WR];
        adO          = wdata_ff;
        cbeOe        = 1'b1;
      end
      H_TDATA:
      begin
        ctlOe          = MSK_TGT;
        ctlO[C_DEVSEL] = 1'b0;
        ctlO[C_TRDY]   = 1'b0;
        adOe           = !tgtWr_ff;
        adO            = mem_ff[tgtIdx_ff];
      end
      H_TURN:  ctlOe = turnInit_ff ? MSK_INIT : MSK_TGT;
    endcase
  end

  assign bus.hstAdO   = adO;
  assign bus.hstAdOe  = adOe;
  assign bus.hstCbeO  = cbeO;
  assign bus.hstCbeOe = cbeOe;
  assign bus.hstCtlO  = ctlO;
  assign bus.hstCtlOe = ctlOe;
  assign bus.hstParO  = parO_ff;
  assign bus.hstParOe = parOe_ff;
  assign bus.hstGntN  = !devGnt_ff;
  assign bus.hstIdsel = state_ff == H_ADDR && ctrl_ff[CT_CFG];
endmodule

// [test/pbc_bus_props.sv]
// Assertions on the shared bus wires between the two ends.
module pbc_bus_props (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [31:0] ad,
  input wire logic [3:0]  cbe,
  input wire logic        par,
  input wire logic [5:0]  ctl,
  input wire logic        devReqN,
  input wire logic        hstGntN,
  input wire logic        hstIdsel
);
  logic parPrev_ff;
  // Parity of last cycle's lines, since the parity line lags by one clock.
  always_ff @(posedge sys_clk)
  begin
    parPrev_ff <= ^{ad, cbe};
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  frame_pulse_a: assert property ($fell(ctl[0]) |=> ctl[0])
    else $error("frame held past address");
  irdy_follow_a: assert property ($fell(ctl[0]) |=> !ctl[1])
    else $error("no irdy after address");
  addr_par_a: assert property ($fell(ctl[0]) |=> par == parPrev_ff)
    else $error("address parity wrong");
  data_par_a: assert property (!ctl[1] && !ctl[2] |=> par == parPrev_ff)
    else $error("data parity wrong");
  irdy_bound_a: assert property ($fell(ctl[0]) |-> ##[2:7] $rose(ctl[1]))
    else $error("transaction never ended");
  trdy_claim_a: assert property (!ctl[2] |-> !ctl[3])
    else $error("trdy without devsel");
  grant_bound_a: assert property ($fell(devReqN) |-> ##[0:30] !hstGntN)
    else $error("request not granted");
  idsel_cfg_a: assert property (hstIdsel |-> !ctl[0] && cbe[3:1] == 3'h5)
    else $error("idsel outside config address");
  cover property ($fell(ctl[0]));
  cover property (!ctl[1] && ctl[3] ##1 ctl[1]);
  cover property (!ctl[1] && !ctl[2]);
endmodule

// [test/pci_bus_control_signalling_tb.sv]
// Bench joining both ends: config, memory, abort and interrupt traffic.
module pci_bus_control_signalling_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pbc_pkg::*;
  logic             sys_clk, rst_n, reqValid, reqWrite, avRd, avWr, cardErr;
  logic [31:0]      reqAddr, reqData, avWd, rd;
  logic [7:0]       avAddr;
  wire logic        reqReady, rspValid, rspAbort, avWait, irq;
  wire logic [31:0] rspData, avRdata;
  int               fails, check_count;
  pbc_bus_if link ();
  pbc_device_end pbc_device_end_inst (.sys_clk(sys_clk), .rst_n(rst_n), .strapN(1'b1),
    .cardAddrParErr(cardErr), .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqData(reqData), .reqLock(1'b0), .rspValid(rspValid),
    .rspAbort(rspAbort), .rspData(rspData), .bus(link));
  pbc_host_end pbc_host_end_inst (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avAddr),
    .avs_read(avRd), .avs_write(avWr), .avs_writedata(avWd), .avs_readdata(avRdata),
    .avs_waitrequest(avWait), .irq(irq), .bus(link));
  pbc_bus_props pbc_bus_props_inst (.sys_clk(sys_clk), .rst_n(rst_n), .ad(link.ad),
    .cbe(link.cbe), .par(link.par), .ctl(link.ctl), .devReqN(link.devReqN),
    .hstGntN(link.hstGntN), .hstIdsel(link.hstIdsel));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Waitrequest is sampled at the rising edge, the same edge at which the slave completes the access.
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avRd <= !w;
    avWr <= w;
    avAddr <= a;
    avWd <= d;
    do @(posedge sys_clk); while (avWait !== 1'b0);
    rd = avRdata;
    avRd <= 1'b0;
    avWr <= 1'b0;
  endtask
  task automatic go(input logic [31:0] c);
    av(1'b1, AV_STAT, 32'hf);
    av(1'b1, AV_CTRL, c);
    rd = '0;
    for (int i = 0; i < 40 && (rd & 32'h3) == '0; i++)
      av(1'b0, AV_STAT, '0);
  endtask
  task automatic dreq(input logic w, input logic [31:0] a, input logic [31:0] d, input logic ab);
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr <= a;
    reqData <= d;
    do @(posedge sys_clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    do @(posedge sys_clk); while (rspValid !== 1'b1);
    chk({31'h0, rspAbort}, {31'h0, ab});
  endtask
  task automatic t_cfg;
    av(1'b1, AV_ADDR, {24'h0, CFG_CMD_OFF});
    av(1'b1, AV_WDATA, 32'hffff_ffff);
    go(32'h7);
    chk(rd & 32'h3, 32'h1);
    go(32'h5);
    av(1'b0, AV_RDATA, '0);
    chk(rd & 32'hffff, {16'h0, CMD_WMASK});
    $display("config test done");
  endtask
  task automatic t_serr;
    av(1'b1, AV_ADDR, {24'h0, CFG_BRG_OFF & 8'hfc});
    av(1'b1, AV_WDATA, 32'h1 << (16 + CSERR_EN_BIT));
    go(32'h7);
    chk(rd & 32'hc, 32'h0);
    @(posedge sys_clk);
    cardErr <= 1'b1;
    @(posedge sys_clk);
    cardErr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    av(1'b0, AV_STAT, '0);
    chk(rd & 32'h8, 32'h8);
    $display("card error test done");
  endtask
  task automatic t_irq;
    av(1'b1, AV_MASK, '0);
    go(32'h1);
    chk(rd & 32'h2, 32'h2);
    chk({31'h0, irq}, 32'h0);
    av(1'b1, AV_MASK, 32'h2);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    av(1'b1, AV_STAT, 32'hf);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    av(1'b0, 8'h20, '0);
    chk(rd, 32'h0);
    $display("abort and interrupt test done");
  endtask
  task automatic t_dev;
    av(1'b1, AV_CTRL, 32'h1 << CT_PARK);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, link.hstGntN}, 32'h0);
    dreq(1'b1, HOST_BASE_DEF, 32'ha5c3_0f96, 1'b0);
    dreq(1'b0, HOST_BASE_DEF, '0, 1'b0);
    chk(rspData, 32'ha5c3_0f96);
    dreq(1'b0, 32'h0, '0, 1'b1);
    $display("device initiator test done");
  endtask
  initial
  begin
    fails = 0;
    check_count = 0;
    rst_n = 1'b0;
    reqValid = 1'b0;
    cardErr = 1'b0;
    reqWrite = 1'b0;
    reqAddr = '0;
    reqData = '0;
    avRd = 1'b0;
    avWr = 1'b0;
    avAddr = '0;
    avWd = '0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_cfg();
    t_serr();
    t_irq();
    t_dev();
    summarize();
  end
  // Well under two hundred cycles are expected; this limit leaves wide margin.
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    summarize();
  end
endmodule
